// *** core/pad_top.sv ***
// Pacing artifact detector top: lead derivation, registers, frame flags
`timescale 1ns/1ps
module pad_top (
   input wire logic i_clk, // System clock 10 MHz
   input wire logic i_rst_n, // Sync reset, active low
   input wire logic i_smp_stb, // 128 kHz sample strobe from decimation
   input wire logic signed [15:0] i_ch1, // Channel 1 sample
   input wire logic signed [15:0] i_ch2, // Channel 2 sample
   input wire logic signed [15:0] i_ch3, // Channel 3 sample
   input wire logic i_frame_start, // Pulse: new ECG frame header
   input wire logic i_frame_inc_pace, // Frame control selects summary word
   input wire logic i_wr, // Register write strobe
   input wire logic i_rd, // Register read strobe
   input wire logic [6:0] i_addr, // Register address
   input wire logic [23:0] i_wdata, // Write data
   output logic [31:0] o_rdata, // Read data
   output logic [2:0] o_hdr_pace, // Pace flags for current header
   output logic o_frame_pace_valid, // Summary word inserted in frame
   output logic [31:0] o_frame_pace_word // Summary word for frame
);
   // Register addresses of threshold and control words
   localparam logic [6:0] ADDR_CH_CTL = 7'h01;
   localparam logic [6:0] ADDR_PACE_CTL = 7'h04;
   localparam logic [6:0] ADDR_REF_CTL = 7'h05;
   localparam logic [6:0] ADDR_AMP = 7'h07;
   localparam logic [6:0] ADDR_EDGE = 7'h0e;
   localparam logic [6:0] ADDR_LVL = 7'h0f;

   typedef struct packed {
      logic analog_lead_config_bit;
      logic common_electrode_ref_bit;
      logic [2:0] en;
      logic [5:0] sel;
      logic filt1;
      logic filt2;
      logic wfilt;
      logic [23:0] edge_th;
      logic [23:0] amp_th;
      logic [23:0] lvl_th;
      logic [2:0] pend;
      logic [2:0] hdr;
      logic [6:0] summ;
      logic [47:0] res;
      logic fvalid;
      logic [31:0] fword;
   } pad_top_t;
   pad_top_t s_r;
   pad_top_t s_nxt;
   logic [2:0] m_valid;
   logic [7:0] m_width [3];
   logic [15:0] m_height [3];
   logic signed [15:0] lead [3];

   // Lead derivation, independent of output rate and filter settings
   function automatic logic signed [15:0] pad_lead(input logic [1:0] sel,
         input logic ana, input logic ce, input logic signed [15:0] c1,
         input logic signed [15:0] c2, input logic signed [15:0] c3);
      logic signed [17:0] v;
      v = '0;
      if (ana) begin
         unique case (sel)
            pad_pkg::LEAD_I: v = 18'(c1);
            pad_pkg::LEAD_II: v = 18'(c2);
            pad_pkg::LEAD_III: v = 18'(c3);
            pad_pkg::LEAD_AVF: v = 18'(c2) - (18'(c1) >>> 1);
         endcase
      end else if (ce) begin
         unique case (sel)
            pad_pkg::LEAD_I: v = 18'(c1);
            pad_pkg::LEAD_II: v = 18'(c2);
            pad_pkg::LEAD_III: v = 18'(c2) - 18'(c1);
            pad_pkg::LEAD_AVF: v = 18'(c2) - (18'(c1) >>> 1);
         endcase
      end else begin
         unique case (sel)
            pad_pkg::LEAD_I: v = 18'(c1) - 18'(c3);
            pad_pkg::LEAD_II: v = 18'(c2) - 18'(c3);
            pad_pkg::LEAD_III: v = 18'(c2) - 18'(c1);
            pad_pkg::LEAD_AVF: v = 18'(c2) - ((18'(c1) + 18'(c3)) >>> 1);
         endcase
      end
      // Saturate to the sample width
      if (v > 18'sd32767)
         v = 18'sd32767;
      else if (v < -18'sd32768)
         v = -18'sd32768;
      return v[15:0];
   endfunction

   // Seven-bit summary: three bits width, four bits height
   function automatic logic [6:0] pad_summ(input logic [7:0] w, input logic [15:0] h);
      logic [2:0] wq;
      logic [3:0] hq;
      wq = (w[7:5] != 3'h0) ? 3'h7 : w[4:2];
      hq = (h[15:13] != 3'h0) ? 4'hf : h[12:9];
      return {hq, wq};
   endfunction

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_m
         assign lead[g] = pad_lead(s_r.sel[2*g +: 2], s_r.analog_lead_config_bit,
               s_r.common_electrode_ref_bit, i_ch1, i_ch2, i_ch3);
         pad_machine u_m (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_en(s_r.en[g]),
            .i_smp_stb(i_smp_stb),
            .i_lead(lead[g]),
            .i_edge_th(s_r.edge_th[8*g +: 8]),
            .i_amp_th(s_r.amp_th[8*g +: 8]),
            .i_lvl_th(s_r.lvl_th[8*g +: 8]),
            .i_filt1(s_r.filt1),
            .i_filt2(s_r.filt2),
            .i_wfilt(s_r.wfilt),
            .o_valid(m_valid[g]),
            .o_width(m_width[g]),
            .o_height(m_height[g])
         );
      end
   endgenerate

   always_comb begin
      s_nxt = s_r;
      s_nxt.fvalid = 1'b0;
      if (i_wr) begin
         unique case (i_addr)
            ADDR_CH_CTL: s_nxt.analog_lead_config_bit = i_wdata[10];
            ADDR_REF_CTL: s_nxt.common_electrode_ref_bit = i_wdata[8];
            ADDR_PACE_CTL: begin
               s_nxt.en = i_wdata[2:0];
               s_nxt.sel = i_wdata[8:3];
               s_nxt.filt1 = i_wdata[pad_pkg::CTL_FILT1_BIT];
               s_nxt.filt2 = i_wdata[pad_pkg::CTL_FILT2_BIT];
               s_nxt.wfilt = i_wdata[pad_pkg::CTL_WIDTH_BIT];
            end
            ADDR_AMP: s_nxt.amp_th = i_wdata;
            ADDR_EDGE: s_nxt.edge_th = i_wdata;
            ADDR_LVL: s_nxt.lvl_th = i_wdata;
            default: ;
         endcase
      end
      // Header flags latched at frame start, then re-armed
      if (i_frame_start) begin
         s_nxt.hdr = s_r.pend;
         s_nxt.pend = 3'h0;
         s_nxt.fvalid = i_frame_inc_pace;
         s_nxt.fword = {8'(pad_pkg::ADDR_SUMMARY), 17'h0, s_r.summ};
      end
      for (int i = 0; i < 3; i++) begin
         if (m_valid[i]) begin
            s_nxt.pend[i] = 1'b1;
            s_nxt.summ = pad_summ(m_width[i], m_height[i]);
            s_nxt.res[16*i +: 16] = {m_width[i], m_height[i][15:8]};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_r <= '0;
         s_r.en <= 3'h7;
         s_r.sel <= {pad_pkg::LEAD_III, pad_pkg::LEAD_II, pad_pkg::LEAD_I};
         s_r.filt1 <= 1'b1;
         s_r.filt2 <= 1'b1;
         s_r.wfilt <= 1'b1;
         s_r.edge_th <= {3{pad_pkg::EDGE_TH_RST}};
         s_r.amp_th <= {3{pad_pkg::AMP_TH_RST}};
         s_r.lvl_th <= {3{pad_pkg::LVL_TH_RST}};
      end else begin
         s_r <= s_nxt;
      end
   end

   always_comb begin
      o_rdata = 32'h0;
      if (i_rd) begin
         unique case (i_addr)
            pad_pkg::ADDR_SUMMARY: o_rdata = {8'(pad_pkg::ADDR_SUMMARY), 17'h0, s_r.summ};
            pad_pkg::ADDR_RES0: o_rdata = {8'(pad_pkg::ADDR_RES0), 8'h0, s_r.res[15:0]};
            pad_pkg::ADDR_RES1: o_rdata = {8'(pad_pkg::ADDR_RES1), 8'h0, s_r.res[31:16]};
            pad_pkg::ADDR_RES2: o_rdata = {8'(pad_pkg::ADDR_RES2), 8'h0, s_r.res[47:32]};
            ADDR_AMP: o_rdata = {8'(ADDR_AMP), s_r.amp_th};
            ADDR_EDGE: o_rdata = {8'(ADDR_EDGE), s_r.edge_th};
            ADDR_LVL: o_rdata = {8'(ADDR_LVL), s_r.lvl_th};
            ADDR_PACE_CTL: o_rdata = {8'(ADDR_PACE_CTL), 12'h0, s_r.wfilt, s_r.filt2,
                                      s_r.filt1, s_r.sel, s_r.en};
            default: o_rdata = 32'h0;
         endcase
      end
   end

   assign o_hdr_pace = s_r.hdr;
   assign o_frame_pace_valid = s_r.fvalid;
   assign o_frame_pace_word = s_r.fword;
endmodule

// *** core/pad_pkg.sv ***
// Package of constants and types for the pacing artifact detector
// Summary of operation
// - Machines consume 16-bit samples at 128 kHz
// - Fixed latency ahead of 2 kHz output
// - Qualify widths 100 us to 2 ms
// - Works with lead-off and respiration enabled
// - Valid pace sets next frame header flag
// - Summary at 0x1A, full results 0x3A-0x3C
// - Summary word streamed only when selected
// - Three independent machines, four selectable leads
// - Lead select codes 00 I to 11 aVF
// - Lead math independent of output settings
// - Digital and common electrode lead formulas
// - Analog leads direct, aVF is II-I/2
// - Search leading edge, peak, trailing edge
// - Per-machine threshold defaults, host overwritable
// - Disabled machine produces no flags, results
// - Shape check, opposite edge, all tests pass
// - Both polarities via leading-edge sign tracking
// - Zero edge threshold means amplitude/2 in leading-edge search
// - Leading edge over 156 us always rejected
// - Shape filters on bits 9, 10, default set
// - Width enable gates minimum width only
package pad_pkg;
   localparam int SAMPLE_HZ = 128000;
   localparam int CLK_HZ = 10000000;
   localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
   localparam int SAMPLE_W = 16;
   localparam int MIN_WIDTH_US = 100;
   localparam int MAX_WIDTH_US = 2000;
   localparam int MAX_EDGE_NS = 156000;
   localparam int MIN_WIDTH_SMP = (MIN_WIDTH_US * SAMPLE_HZ + 999999) / 1000000;
   localparam int MAX_WIDTH_SMP = (MAX_WIDTH_US * SAMPLE_HZ) / 1000000;
   localparam int MAX_EDGE_SMP = (MAX_EDGE_NS / 1000 * SAMPLE_HZ) / 1000000;
   localparam int LEVEL_GAP_SMP = 2;
   localparam int SHAPE_SMP = 2;
   localparam logic [7:0] EDGE_TH_RST = 8'h00;
   localparam logic [7:0] AMP_TH_RST = 8'h24;
   localparam logic [7:0] LVL_TH_RST = 8'h00;
   localparam logic [6:0] ADDR_SUMMARY = 7'h1a;
   localparam logic [6:0] ADDR_RES0 = 7'h3a;
   localparam logic [6:0] ADDR_RES1 = 7'h3b;
   localparam logic [6:0] ADDR_RES2 = 7'h3c;
   localparam int CTL_FILT1_BIT = 9;
   localparam int CTL_FILT2_BIT = 10;
   localparam int CTL_WIDTH_BIT = 11;
   localparam logic [1:0] LEAD_I = 2'h0;
   localparam logic [1:0] LEAD_II = 2'h1;
   localparam logic [1:0] LEAD_III = 2'h2;
   localparam logic [1:0] LEAD_AVF = 2'h3;
   typedef enum logic [4:0] {
      PAD_IDLE = 5'h01,
      PAD_EDGE = 5'h02,
      PAD_LEVEL = 5'h04,
      PAD_TOP = 5'h08,
      PAD_DONE = 5'h10
   } pad_state_t;
endpackage

// *** core/pad_machine.sv ***
// One pace detection state machine
`timescale 1ns/1ps
module pad_machine (
   input wire logic i_clk, // System clock
   input wire logic i_rst_n, // Sync reset
   input wire logic i_en, // Machine enable
   input wire logic i_smp_stb, // 128 kHz sample strobe
   input wire logic signed [15:0] i_lead, // Lead sample
   input wire logic [7:0] i_edge_th, // Edge threshold
   input wire logic [7:0] i_amp_th, // Amplitude threshold
   input wire logic [7:0] i_lvl_th, // Level slope threshold
   input wire logic i_filt1, // Shape filter 1 enable
   input wire logic i_filt2, // Shape filter 2 enable
   input wire logic i_wfilt, // Minimum width enable
   output logic o_valid, // One-cycle valid pace pulse
   output logic [7:0] o_width, // Width in samples
   output logic [15:0] o_height // Height magnitude
);
   typedef struct packed {
      pad_pkg::pad_state_t st;
      logic signed [15:0] base;
      logic signed [15:0] prev;
      logic neg;
      logic [8:0] cnt;
      logic [7:0] edge_cnt;
      logic [15:0] peak;
      logic valid;
      logic [7:0] width;
      logic [15:0] height;
   } pad_m_t;
   pad_m_t s_r;
   pad_m_t s_nxt;
   logic signed [16:0] dev;
   logic signed [16:0] adj;
   logic signed [16:0] edge_s;
   logic [15:0] mag;
   logic signed [16:0] slope;
   logic [15:0] edge_eff;

   always_comb begin
      s_nxt = s_r;
      s_nxt.valid = 1'b0;
      dev = 17'(i_lead) - 17'(s_r.base);
      // Polarity-adjusted deviation, zero once it swings past the baseline
      adj = s_r.neg ? -dev : dev;
      mag = adj[16] ? 16'h0000 : adj[15:0];
      slope = s_r.neg ? 17'(s_r.prev) - 17'(i_lead) : 17'(i_lead) - 17'(s_r.prev);
      edge_eff = (i_edge_th == 8'h00) ? 16'(i_amp_th >> 1) : 16'(i_edge_th);
      edge_s = signed'({1'b0, edge_eff});
      if (!i_en) begin
         s_nxt.st = pad_pkg::PAD_IDLE;
         if (i_smp_stb)
            s_nxt.base = i_lead;
      end else if (i_smp_stb) begin
         s_nxt.prev = i_lead;
         unique case (s_r.st)
            pad_pkg::PAD_IDLE: begin
               // Leading edge against recent baseline, either sign
               if (dev > edge_s || -dev > edge_s) begin
                  s_nxt.neg = dev[16];
                  s_nxt.st = pad_pkg::PAD_EDGE;
                  s_nxt.edge_cnt = 8'h01;
                  s_nxt.cnt = 9'h001;
               end else begin
                  s_nxt.base = i_lead;
               end
            end
            pad_pkg::PAD_EDGE: begin
               s_nxt.cnt = s_r.cnt + 9'h001;
               if (s_r.edge_cnt != 8'hff)
                  s_nxt.edge_cnt = s_r.edge_cnt + 8'h01;
               // Leading edge ends when slope falls to level threshold
               if (slope <= 17'(signed'(i_lvl_th))) begin
                  if (s_r.edge_cnt > 8'(pad_pkg::MAX_EDGE_SMP)) begin
                     // Slow edge: plateau becomes baseline, no restart on it
                     s_nxt.base = i_lead;
                     s_nxt.st = pad_pkg::PAD_IDLE;
                  end else if (mag < {7'h00, i_amp_th, 1'b0}) begin
                     s_nxt.st = pad_pkg::PAD_IDLE;
                  end else begin
                     s_nxt.peak = mag;
                     s_nxt.st = pad_pkg::PAD_LEVEL;
                  end
               end
            end
            pad_pkg::PAD_LEVEL: begin
               s_nxt.cnt = s_r.cnt + 9'h001;
               if (mag > s_r.peak)
                  s_nxt.peak = mag;
               // Shape filters: top must hold near the peak
               if ((i_filt1 && mag < (s_r.peak >> 1)) ||
                   (i_filt2 && s_r.cnt < 9'(pad_pkg::SHAPE_SMP) &&
                    slope < -signed'({1'b0, s_r.peak >> 2})))
                  s_nxt.st = pad_pkg::PAD_IDLE;
               else if (s_r.cnt >= 9'(pad_pkg::LEVEL_GAP_SMP))
                  s_nxt.st = pad_pkg::PAD_TOP;
            end
            pad_pkg::PAD_TOP: begin
               s_nxt.cnt = s_r.cnt + 9'h001;
               if (mag > s_r.peak)
                  s_nxt.peak = mag;
               if (s_r.cnt > 9'(pad_pkg::MAX_WIDTH_SMP)) begin
                  s_nxt.st = pad_pkg::PAD_IDLE;
               end else if (mag < 16'(i_edge_th) || mag < (s_r.peak >> 1)) begin
                  // Opposite-polarity trailing edge found
                  if (i_wfilt && s_r.cnt < 9'(pad_pkg::MIN_WIDTH_SMP))
                     s_nxt.st = pad_pkg::PAD_IDLE;
                  else
                     s_nxt.st = pad_pkg::PAD_DONE;
               end
            end
            pad_pkg::PAD_DONE: begin
               s_nxt.valid = 1'b1;
               s_nxt.width = (s_r.cnt > 9'h0ff) ? 8'hff : s_r.cnt[7:0];
               s_nxt.height = s_r.peak;
               s_nxt.base = i_lead;
               s_nxt.st = pad_pkg::PAD_IDLE;
            end
            default: s_nxt.st = pad_pkg::PAD_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_r <= '{st: pad_pkg::PAD_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_valid = s_r.valid;
   assign o_width = s_r.width;
   assign o_height = s_r.height;
endmodule

// *** dv/pad_monitor.sv ***
// Port checker for the pace detector top
`timescale 1ns/1ps
module pad_monitor (
   input wire logic i_clk, // Clock
   input wire logic i_rst_n, // Sync reset
   input wire logic i_frame_start, // Frame header pulse
   input wire logic i_frame_inc_pace, // Summary selected
   input wire logic i_rd, // Read strobe
   input wire logic [6:0] i_addr, // Address
   input wire logic [31:0] o_rdata, // Read data
   input wire logic [2:0] o_hdr_pace, // Header flags
   input wire logic o_frame_pace_valid, // Summary in frame
   input wire logic [31:0] o_frame_pace_word // Summary word
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   chk_hdr_frame_only: assert property ($changed(o_hdr_pace) |-> $past(i_frame_start))
      else $error("header flags moved outside a frame start");
   chk_hdr_after_reset: assert property ($rose(i_rst_n) |-> o_hdr_pace == 3'h0)
      else $error("header flags set after reset");
   chk_word_cause: assert property (o_frame_pace_valid |-> $past(i_frame_start)
      && $past(i_frame_inc_pace))
      else $error("summary word without selected frame");
   chk_word_inserted: assert property (i_frame_start && i_frame_inc_pace |=> o_frame_pace_valid)
      else $error("selected summary word missing");
   chk_word_single: assert property (o_frame_pace_valid && !i_frame_start |=> !o_frame_pace_valid)
      else $error("summary word valid too long");
   chk_word_format: assert property (o_frame_pace_valid |-> o_frame_pace_word[31:24] == 8'h1a
      && o_frame_pace_word[23:7] == 17'h0)
      else $error("summary word format wrong");
   chk_read_idle: assert property (!i_rd |-> o_rdata == 32'h0)
      else $error("read data without read");
   chk_read_unmapped: assert property (i_rd && !(i_addr inside {7'h01, 7'h04, 7'h05, 7'h07,
      7'h0e, 7'h0f, 7'h1a, 7'h3a, 7'h3b, 7'h3c}) |-> o_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind pad_top pad_monitor i_mon (.i_clk, .i_rst_n, .i_frame_start, .i_frame_inc_pace, .i_rd,
   .i_addr, .o_rdata, .o_hdr_pace, .o_frame_pace_valid, .o_frame_pace_word);

// *** dv/pad_source.sv ***
// Decimation chain model: sample strobe and pulse-shaped channels
`timescale 1ns/1ps
module pad_source (
   input wire logic i_clk, // Clock
   input wire logic i_rst_n, // Sync reset
   input wire logic i_go, // Start one pulse
   input wire logic signed [15:0] i_amp, // Pulse amplitude
   input wire logic [9:0] i_width, // Width in samples
   input wire logic [5:0] i_ramp, // Leading edge samples
   input wire logic [2:0] i_mask, // Channels carrying pulse
   output logic o_smp_stb, // Sample strobe
   output logic signed [15:0] o_ch1, // Channel 1
   output logic signed [15:0] o_ch2, // Channel 2
   output logic signed [15:0] o_ch3, // Channel 3
   output logic o_busy // Pulse in progress
);
   logic [6:0] div;
   logic [9:0] idx;
   logic signed [15:0] lvl;
   logic signed [15:0] junk;
   assign o_smp_stb = (div == 7'(pad_pkg::SAMPLE_DIV - 1));
   // Channels only valid with the strobe
   assign junk = {div, div, 2'h3};
   assign o_ch1 = o_smp_stb ? (i_mask[0] ? lvl : 16'sh0) : junk;
   assign o_ch2 = o_smp_stb ? (i_mask[1] ? lvl : 16'sh0) : ~junk;
   assign o_ch3 = o_smp_stb ? (i_mask[2] ? lvl : 16'sh0) : junk;
   always_comb begin
      if (!o_busy || idx < 10'd16 || idx >= 10'd16 + i_width) begin
         lvl = 16'sh0;
      end else if (idx < 10'd16 + 10'(i_ramp)) begin
         lvl = 16'(int'(i_amp) * (int'(idx) - 15) / int'(i_ramp));
      end else begin
         lvl = i_amp;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         div <= 7'h0;
         idx <= 10'h0;
         o_busy <= 1'b0;
      end else begin
         div <= o_smp_stb ? 7'h0 : div + 7'h1;
         if (i_go) begin
            o_busy <= 1'b1;
            idx <= 10'h0;
         end else if (o_busy && o_smp_stb) begin
            idx <= idx + 10'h1;
            if (idx == i_width + 10'd32) begin
               o_busy <= 1'b0;
            end
         end
      end
   end
endmodule

// *** dv/pad_top_tb.sv ***
// Self-checking testbench for the pace detector top
`timescale 1ns/1ps
module pad_top_tb;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_smp_stb;
   logic signed [15:0] i_ch1, i_ch2, i_ch3;
   logic i_frame_start = 1'b0;
   logic i_frame_inc_pace = 1'b0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [6:0] i_addr = 7'h0;
   logic [23:0] i_wdata = 24'h0;
   logic [31:0] o_rdata, o_frame_pace_word, d;
   logic [2:0] o_hdr_pace;
   logic o_frame_pace_valid, busy;
   logic go = 1'b0;
   logic signed [15:0] amp = 16'sh0;
   logic [9:0] width = 10'd1;
   logic [5:0] ramp = 6'd1;
   logic [2:0] mask = 3'h0;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #50 i_clk = ~i_clk;
   pad_top i_dut (.i_clk, .i_rst_n, .i_smp_stb, .i_ch1, .i_ch2, .i_ch3, .i_frame_start,
      .i_frame_inc_pace, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_hdr_pace,
      .o_frame_pace_valid, .o_frame_pace_word);
   pad_source i_src (.i_clk, .i_rst_n, .i_go(go), .i_amp(amp), .i_width(width), .i_ramp(ramp),
      .i_mask(mask), .o_smp_stb(i_smp_stb), .o_ch1(i_ch1), .o_ch2(i_ch2), .o_ch3(i_ch3),
      .o_busy(busy));
   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         num_errors++;
         finish_test;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [23:0] v);
      @(posedge i_clk) i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk) i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a);
      @(posedge i_clk) i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk) d = o_rdata;
      i_rd <= 1'b0;
   endtask
   task automatic pulse(input logic signed [15:0] a, input logic [9:0] w, input logic [5:0] r);
      @(posedge i_clk) go <= 1'b1;
      amp <= a;
      width <= w;
      ramp <= r;
      @(posedge i_clk) go <= 1'b0;
      @(posedge i_clk);
      for (int k = 0; k < 40000 && busy; k++) @(posedge i_clk);
   endtask
   task automatic frame(input logic inc, input logic [2:0] eh, input logic ef);
      @(posedge i_clk) i_frame_start <= 1'b1;
      i_frame_inc_pace <= inc;
      @(posedge i_clk) i_frame_start <= 1'b0;
      #1;
      chk("hdr_pace", 32'(eh), 32'(o_hdr_pace));
      chk("frame_valid", 32'(ef), 32'(o_frame_pace_valid));
      $display("frame step done, hdr %b", o_hdr_pace);
   endtask
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(7'h04);
      chk("ctl_default", 32'h000f27, 32'(d[23:0]));
      rd(7'h07);
      chk("amp_default", 32'h242424, 32'(d[23:0]));
      rd(7'h20);
      chk("unmapped", 32'h0, d);
      wr(7'h0e, 24'h030201);
      rd(7'h0e);
      chk("edge_th", 32'h030201, 32'(d[23:0]));
      mask <= 3'b011;
      pulse(-16'sh1000, 10'd24, 6'd1);
      frame(1'b1, 3'b011, 1'b1);
      chk("summary", 32'h46, 32'(o_frame_pace_word[6:0]));
      for (int m = 0; m < 2; m++) begin
         rd(7'h3a + 7'(m));
         chk("res_height", 32'h10, 32'(d[7:0]));
         chk("res_width", 32'h1, 32'(d[15:8] >= 8'd23 && d[15:8] <= 8'd25));
      end
      frame(1'b0, 3'b000, 1'b0);
      wr(7'h04, 24'h000f26);
      pulse(16'sh1000, 10'd24, 6'd1);
      frame(1'b0, 3'b010, 1'b0);
      mask <= 3'b010;
      for (int c = 0; c < 4; c++) begin
         wr(7'h04, 24'h000e07 | (24'(c * 8'h15) << 3));
         pulse(16'sh1000, 10'd24, 6'd1);
         frame(1'b1, (c == 0) ? 3'b000 : 3'b111, 1'b1);
      end
      wr(7'h01, 24'h000400);
      wr(7'h04, 24'h000f57);
      mask <= 3'b100;
      pulse(16'sh1000, 10'd24, 6'd1);
      frame(1'b0, 3'b111, 1'b0);
      wr(7'h01, 24'h000000);
      wr(7'h05, 24'h000100);
      wr(7'h04, 24'h000f27);
      pulse(16'sh1000, 10'd24, 6'd1);
      frame(1'b0, 3'b000, 1'b0);
      wr(7'h05, 24'h000000);
      mask <= 3'b011;
      pulse(16'sh1000, 10'd8, 6'd1);
      frame(1'b0, 3'b000, 1'b0);
      pulse(16'sh1000, 10'd265, 6'd1);
      frame(1'b0, 3'b000, 1'b0);
      pulse(16'sh1000, 10'd60, 6'd30);
      frame(1'b0, 3'b000, 1'b0);
      finish_test;
   end
endmodule
